/* File: design/bse_branch_cond.sv */
// Branch condition evaluation on the flag register.
`timescale 1ns/1ps
`include "bse_regs.svh"

module bse_branch_cond (
    input  wire bse_pkg::bse_br_cond_t cond,
    input  wire logic [2:0]            bit_sel,
    input  wire logic [7:0]            flags,
    output logic                       taken
);

    // ======================================================================
    // Condition select
    always_comb begin
        unique case (cond)
            bse_pkg::BSE_BR_FLAG_SET_GENERIC:   taken = flags[bit_sel];
            bse_pkg::BSE_BR_FLAG_CLEAR_GENERIC: taken = !flags[bit_sel];
            bse_pkg::BSE_BR_EQUAL:              taken = flags[`BSE_FLAG_Z];
            bse_pkg::BSE_BR_NOT_EQUAL:          taken = !flags[`BSE_FLAG_Z];
            bse_pkg::BSE_BR_CARRY_SET,
            bse_pkg::BSE_BR_LOWER:              taken = flags[`BSE_FLAG_C];
            bse_pkg::BSE_BR_CARRY_CLEAR,
            bse_pkg::BSE_BR_SAME_OR_HIGHER:     taken = !flags[`BSE_FLAG_C];
            bse_pkg::BSE_BR_MINUS:              taken = flags[`BSE_FLAG_N];
            bse_pkg::BSE_BR_PLUS:               taken = !flags[`BSE_FLAG_N];
            // The signed pair reads N and V directly, not the stored S bit.
            bse_pkg::BSE_BR_SIGNED_GE:
                taken = !(flags[`BSE_FLAG_N] ^ flags[`BSE_FLAG_V]);
            bse_pkg::BSE_BR_SIGNED_LT:
                taken = flags[`BSE_FLAG_N] ^ flags[`BSE_FLAG_V];
            bse_pkg::BSE_BR_HALF_CARRY_SET:     taken = flags[`BSE_FLAG_H];
            bse_pkg::BSE_BR_HALF_CARRY_CLEAR:   taken = !flags[`BSE_FLAG_H];
            bse_pkg::BSE_BR_TRANSFER_BIT_SET:   taken = flags[`BSE_FLAG_T];
            bse_pkg::BSE_BR_TRANSFER_BIT_CLEAR: taken = !flags[`BSE_FLAG_T];
            bse_pkg::BSE_BR_OVERFLOW_SET:       taken = flags[`BSE_FLAG_V];
            bse_pkg::BSE_BR_OVERFLOW_CLEAR:     taken = !flags[`BSE_FLAG_V];
            bse_pkg::BSE_BR_IRQ_ENABLED:        taken = flags[`BSE_FLAG_I];
            bse_pkg::BSE_BR_IRQ_DISABLED:       taken = !flags[`BSE_FLAG_I];
            // Unused codes never branch, so a bad decode falls through.
            default:                            taken = 1'b0;
        endcase
    end

endmodule : bse_branch_cond

/* File: design/bse_exec.sv */
// Execution of skips, flag branches, I/O bit writes and logical shifts.
`timescale 1ns/1ps
`include "bse_regs.svh"

module bse_exec (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire logic                   instr_valid,
    input  wire bse_pkg::bse_instr_t    instr,
    input  wire logic [`BSE_PC_W-1:0]   pc_in,
    input  wire logic [7:0]             flags_in,
    output logic                        instr_ready,
    output bse_pkg::bse_result_t        result
);

    // ======================================================================
    // Types and helpers

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } bse_state_t;

    // Word address arithmetic wraps at the top of program space.
    function automatic logic [`BSE_PC_W-1:0] pc_add(
        input logic [`BSE_PC_W-1:0] base,
        input logic [`BSE_PC_W-1:0] delta
    );
        logic [`BSE_PC_W-1:0] sum;
        sum = base + delta;
        return sum;
    endfunction : pc_add

    // The branch displacement is a signed word count.
    function automatic logic [`BSE_PC_W-1:0] sign_extend(
        input logic [`BSE_OFS_W-1:0] ofs
    );
        return {{(`BSE_PC_W - `BSE_OFS_W){ofs[`BSE_OFS_W-1]}}, ofs};
    endfunction : sign_extend

    // ======================================================================
    // State

    bse_state_t            state_reg;
    bse_state_t            state_next;
    logic [1:0]            cnt_reg;
    logic [1:0]            cnt_next;
    logic                  ready_reg;
    logic                  ready_next;
    bse_pkg::bse_result_t  pend_reg;
    bse_pkg::bse_result_t  pend_next;
    bse_pkg::bse_result_t  result_reg;
    bse_pkg::bse_result_t  result_next;

    // ======================================================================
    // Operation decode results

    bse_pkg::bse_result_t  work;
    logic [1:0]            work_cycles;
    logic                  br_taken;
    logic                  skip_hit;
    logic                  opnd_bit;
    logic [7:0]            bit_mask;
    logic [7:0]            shift_data;
    logic [7:0]            shift_flags;
    logic                  accept;

    assign accept = instr_valid && ready_reg;

    bse_branch_cond u_branch_cond (
        .cond    (instr.cond),
        .bit_sel (instr.bit_sel),
        .flags   (flags_in),
        .taken   (br_taken)
    );

    bse_shift_unit u_shift_unit (
        .dir_right (instr.op == bse_pkg::BSE_OP_SHIFT_RIGHT),
        .din       (instr.opnd),
        .flags_in  (flags_in),
        .dout      (shift_data),
        .flags_out (shift_flags)
    );

    // ======================================================================
    // Per-instruction result and cycle count

    always_comb begin
        opnd_bit    = instr.opnd[instr.bit_sel];
        bit_mask    = 8'h01 << instr.bit_sel;
        skip_hit    = 1'b0;
        work_cycles = `BSE_CYC_ONE;
        work          = '0;
        work.done     = 1'b1;
        work.next_pc  = pc_add(pc_in, `BSE_STEP_NEXT);
        work.flags    = flags_in;
        work.io_addr  = instr.io_addr;
        work.io_data  = instr.opnd;
        work.rd_data  = instr.opnd;
        unique case (instr.op)
            bse_pkg::BSE_OP_SKIP_REG_CLR: begin
                skip_hit = !opnd_bit;
            end
            bse_pkg::BSE_OP_SKIP_REG_SET: begin
                skip_hit = opnd_bit;
            end
            bse_pkg::BSE_OP_SKIP_IO_CLR: begin
                skip_hit = !opnd_bit;
            end
            bse_pkg::BSE_OP_SKIP_IO_SET: begin
                skip_hit = opnd_bit;
            end
            bse_pkg::BSE_OP_BRANCH: begin
                // Flags are read only; the branch never writes them.
                if (br_taken) begin
                    work.next_pc = pc_add(pc_add(pc_in, sign_extend(instr.offset)),
                                          `BSE_STEP_NEXT);
                    work_cycles  = `BSE_CYC_TWO;
                end
            end
            bse_pkg::BSE_OP_IO_SET: begin
                work.io_we   = 1'b1;
                work.io_data = instr.opnd | bit_mask;
                work_cycles  = `BSE_CYC_TWO;
            end
            bse_pkg::BSE_OP_IO_CLR: begin
                work.io_we   = 1'b1;
                work.io_data = instr.opnd & ~bit_mask;
                work_cycles  = `BSE_CYC_TWO;
            end
            bse_pkg::BSE_OP_SHIFT_LEFT,
            bse_pkg::BSE_OP_SHIFT_RIGHT: begin
                work.rd_we    = 1'b1;
                work.rd_data  = shift_data;
                work.flags_we = 1'b1;
                work.flags    = shift_flags;
            end
            // An unknown operation retires as a one-cycle no-op.
            default: begin
                work.done = 1'b1;
            end
        endcase
        if (skip_hit) begin
            if (instr.next_two_word) begin
                work.next_pc = pc_add(pc_in, `BSE_STEP_SKIP2);
                work_cycles  = `BSE_CYC_THREE;
            end else begin
                work.next_pc = pc_add(pc_in, `BSE_STEP_SKIP1);
                work_cycles  = `BSE_CYC_TWO;
            end
        end
    end

    // ======================================================================
    // Sequencer next state

    // The result is held back until the last cycle of the instruction, so
    // the fetch side sees the new PC exactly when the cycle count expires.
    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        ready_next  = ready_reg;
        pend_next   = pend_reg;
        result_next = '0;
        result_next.next_pc = result_reg.next_pc;
        unique case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    if (work_cycles == `BSE_CYC_ONE) begin
                        result_next = work;
                    end else begin
                        pend_next  = work;
                        cnt_next   = work_cycles - `BSE_CYC_ONE;
                        ready_next = 1'b0;
                        state_next = ST_BUSY;
                    end
                end
            end
            ST_BUSY: begin
                if (cnt_reg == `BSE_CYC_ONE) begin
                    result_next = pend_reg;
                    ready_next  = 1'b1;
                    state_next  = ST_IDLE;
                end
                cnt_next = cnt_reg - `BSE_CYC_ONE;
            end
        endcase
    end

    // ======================================================================
    // Sequencer registers

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg  <= ST_IDLE;
            cnt_reg    <= 2'h0;
            ready_reg  <= 1'b1;
            pend_reg   <= '0;
            result_reg <= '0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            ready_reg  <= ready_next;
            pend_reg   <= pend_next;
            result_reg <= result_next;
        end
    end

    assign instr_ready = ready_reg;
    assign result      = result_reg;

endmodule : bse_exec

/* File: design/bse_pkg.sv */
// Types shared by the branch, skip and bit-operation execution block.
`include "bse_regs.svh"

package bse_pkg;

    // ======================================================================
    // Operation groups handed over by the decoder
    typedef enum logic [3:0] {
        BSE_OP_NONE         = 4'h0,
        BSE_OP_SKIP_REG_CLR = 4'h1,
        BSE_OP_SKIP_REG_SET = 4'h2,
        BSE_OP_SKIP_IO_CLR  = 4'h3,
        BSE_OP_SKIP_IO_SET  = 4'h4,
        BSE_OP_BRANCH       = 4'h5,
        BSE_OP_IO_SET       = 4'h6,
        BSE_OP_IO_CLR       = 4'h7,
        BSE_OP_SHIFT_LEFT   = 4'h8,
        BSE_OP_SHIFT_RIGHT  = 4'h9
    } bse_op_t;

    // ======================================================================
    // Branch conditions, one per branch form
    typedef enum logic [4:0] {
        BSE_BR_FLAG_SET_GENERIC   = 5'h00,
        BSE_BR_FLAG_CLEAR_GENERIC = 5'h01,
        BSE_BR_EQUAL              = 5'h02,
        BSE_BR_NOT_EQUAL          = 5'h03,
        BSE_BR_CARRY_SET          = 5'h04,
        BSE_BR_CARRY_CLEAR        = 5'h05,
        BSE_BR_SAME_OR_HIGHER     = 5'h06,
        BSE_BR_LOWER              = 5'h07,
        BSE_BR_MINUS              = 5'h08,
        BSE_BR_PLUS               = 5'h09,
        BSE_BR_SIGNED_GE          = 5'h0a,
        BSE_BR_SIGNED_LT          = 5'h0b,
        BSE_BR_HALF_CARRY_SET     = 5'h0c,
        BSE_BR_HALF_CARRY_CLEAR   = 5'h0d,
        BSE_BR_TRANSFER_BIT_SET   = 5'h0e,
        BSE_BR_TRANSFER_BIT_CLEAR = 5'h0f,
        BSE_BR_OVERFLOW_SET       = 5'h10,
        BSE_BR_OVERFLOW_CLEAR     = 5'h11,
        BSE_BR_IRQ_ENABLED        = 5'h12,
        BSE_BR_IRQ_DISABLED       = 5'h13
    } bse_br_cond_t;

    // ======================================================================
    // One decoded instruction
    typedef struct packed {
        bse_op_t                     op;
        bse_br_cond_t                cond;
        logic [2:0]                  bit_sel;
        logic [7:0]                  opnd;
        logic [`BSE_IO_ADDR_W-1:0]   io_addr;
        logic [`BSE_OFS_W-1:0]       offset;
        logic                        next_two_word;
    } bse_instr_t;

    // ======================================================================
    // Completion of one instruction
    typedef struct packed {
        logic                        done;
        logic [`BSE_PC_W-1:0]        next_pc;
        logic                        flags_we;
        logic [7:0]                  flags;
        logic                        rd_we;
        logic [7:0]                  rd_data;
        logic                        io_we;
        logic [`BSE_IO_ADDR_W-1:0]   io_addr;
        logic [7:0]                  io_data;
    } bse_result_t;

endpackage : bse_pkg

/* File: design/bse_regs.svh */
// Constants of the branch, skip and bit-operation execution block.
//
// What this block does
// - Register bit zero skips next instruction, PC plus 2 or 3, 1/2/3 cycles.
// - Register bit one skips next instruction, PC plus 2 or 3, 1/2/3 cycles.
// - I/O register bit zero skips next instruction, PC plus 2 or 3, 1/2/3 cycles.
// - I/O register bit one skips next instruction, PC plus 2 or 3, 1/2/3 cycles.
// - Generic set-branch jumps to PC plus offset plus one when chosen flag is one.
// - Generic clear-branch jumps to PC plus offset plus one when chosen flag is zero.
// - Equal branches on zero flag one, not-equal on zero flag zero.
// - Carry-set and lower branch on carry one; carry-clear and same-or-higher on zero.
// - Minus branches on negative flag one, plus on negative flag zero.
// - Signed greater-or-equal branches on N xor V zero, less-than on one.
// - Half-carry branches test the half-carry flag for one or zero.
// - Transfer-bit branches test the T flag for one or zero.
// - Overflow branches test the overflow flag for one or zero.
// - Interrupt-state branches test the global interrupt enable for one or zero.
// - I/O bit-set forces one bit to one, keeps others, no flags, two cycles.
// - I/O bit-clear forces one bit to zero, keeps others, no flags, two cycles.
// - Left shift fills bit zero with zero, updates Z C N V in one cycle.
// - Right shift fills bit seven with zero, updates Z C N V in one cycle.
`ifndef BSE_REGS_SVH
`define BSE_REGS_SVH

// ==========================================================================
// Widths
`define BSE_PC_W        11
`define BSE_OFS_W       7
`define BSE_IO_ADDR_W   5

// ==========================================================================
// Flag register bit positions
`define BSE_FLAG_C      3'h0
`define BSE_FLAG_Z      3'h1
`define BSE_FLAG_N      3'h2
`define BSE_FLAG_V      3'h3
`define BSE_FLAG_S      3'h4
`define BSE_FLAG_H      3'h5
`define BSE_FLAG_T      3'h6
`define BSE_FLAG_I      3'h7

// ==========================================================================
// Program counter steps in words
`define BSE_STEP_NEXT   11'h001
`define BSE_STEP_SKIP1  11'h002
`define BSE_STEP_SKIP2  11'h003

// ==========================================================================
// Execution times in clock cycles
`define BSE_CYC_ONE     2'h1
`define BSE_CYC_TWO     2'h2
`define BSE_CYC_THREE   2'h3

// ==========================================================================
// Reset values
`define BSE_RST_PC      11'h000
`define BSE_RST_BYTE    8'h00

`endif

/* File: design/bse_shift_unit.sv */
// One-bit logical shifter with its flag update.
`timescale 1ns/1ps
`include "bse_regs.svh"

module bse_shift_unit (
    input  wire logic       dir_right,
    input  wire logic [7:0] din,
    input  wire logic [7:0] flags_in,
    output logic [7:0]      dout,
    output logic [7:0]      flags_out
);

    logic carry;
    logic neg;

    // ======================================================================
    // Shift and flags
    always_comb begin
        if (dir_right) begin
            dout  = {1'b0, din[7:1]};
            carry = din[0];
        end else begin
            dout  = {din[6:0], 1'b0};
            carry = din[7];
        end
        neg       = dout[7];
        // Only Z, C, N and V move; every other flag passes unchanged.
        flags_out = flags_in;
        flags_out[`BSE_FLAG_C] = carry;
        flags_out[`BSE_FLAG_Z] = (dout == 8'h00);
        flags_out[`BSE_FLAG_N] = neg;
        flags_out[`BSE_FLAG_V] = neg ^ carry;
    end

endmodule : bse_shift_unit

/* File: verification/branch_skip_bitop_exec_test.sv */
// Self-checking testbench of the execution block.
`timescale 1ns/1ps
`include "bse_regs.svh"
module branch_skip_bitop_exec_test;
    logic                 clk;
    logic                 reset;
    logic                 instr_valid;
    bse_pkg::bse_instr_t  instr;
    bse_pkg::bse_instr_t  ins;
    logic [`BSE_PC_W-1:0] pc_in;
    logic [7:0]           flags_in;
    logic                 instr_ready;
    bse_pkg::bse_result_t result;
    bse_pkg::bse_result_t res;
    logic [7:0]           io_val;
    int                   cyc;
    int                   errors;
    int                   samples_checked;

    bse_exec i_dut (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr), .pc_in(pc_in),
        .flags_in(flags_in), .instr_ready(instr_ready), .result(result));
    bse_io_model i_io (.clk(clk), .reset(reset), .rd_addr(5'h1f), .rd_data(io_val), .wr_en(result.io_we),
        .wr_addr(result.io_addr), .wr_data(result.io_data));

    always #2 clk = ~clk;

    // ==================================================================
    // Common tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // Presents ins for one accept edge, then counts cycles until retirement.
    task automatic run(input logic [10:0] pc, input logic [7:0] f);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr       <= ins;
        pc_in       <= pc;
        flags_in    <= f;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        cyc = 1;
        while (result.done !== 1'b1 && cyc < 8) begin
            @(posedge clk);
            #1;
            cyc++;
        end
        res = result;
        if (result.done !== 1'b1) begin
            errors++;
            end_of_test();
        end
    endtask : run

    function automatic logic exp_taken(input logic [4:0] c, input logic [2:0] b, input logic [7:0] f);
        logic t;
        case (c[4:1])
            4'h0: t = f[b];
            4'h1: t = f[1];
            4'h2, 4'h3: t = f[0];
            4'h4: t = f[2];
            4'h5: t = ~(f[2] ^ f[3]);
            4'h6: t = f[5];
            4'h7: t = f[6];
            4'h8: t = f[3];
            default: t = f[7];
        endcase
        // Codes 6 and 7 reverse the usual polarity of the low code bit.
        return (c == 5'h06 || c == 5'h07) ? ~(t ^ c[0]) : t ^ c[0];
    endfunction : exp_taken

    // ==================================================================
    // Scenarios
    task automatic test_io_bits;
        logic [7:0] sh;
        sh = 8'h00;
        for (int n = 0; n < 16; n++) begin
            ins         = '0;
            ins.op      = n < 8 ? bse_pkg::BSE_OP_IO_SET : bse_pkg::BSE_OP_IO_CLR;
            ins.bit_sel = n < 8 ? 3'(n) : 3'(2 * n + 1);
            ins.io_addr = 5'h1f;
            ins.opnd    = sh;
            sh = n < 8 ? sh | (8'h01 << ins.bit_sel) : sh & ~(8'h01 << ins.bit_sel);
            run(11'h020, 8'h5a);
            check("io data", 16'(res.io_data), 16'(sh));
            check("io strobes", 16'({res.io_we, res.flags_we, res.rd_we, res.io_addr}), 16'h009f);
            check("io cycles", 16'(cyc), 16'h0002);
        end
        @(posedge clk);
        #1;
        check("io model", 16'(io_val), 16'h0055);
        $display("test_io_bits finished");
    endtask : test_io_bits

    task automatic test_branches;
        logic [7:0]  fl [3] = '{8'h00, 8'hff, 8'h04};
        logic [10:0] pc;
        logic [10:0] exp_pc;
        logic        tk;
        for (int k = 0; k < 3; k++) begin
            for (int c = 0; c < 20; c++) begin
                ins         = '0;
                ins.op      = bse_pkg::BSE_OP_BRANCH;
                ins.cond    = bse_pkg::bse_br_cond_t'(c);
                ins.bit_sel = 3'(c + k);
                ins.offset  = c[0] ? 7'h40 : 7'h3f;
                pc          = 11'h7f0 + 11'(c);
                tk          = exp_taken(5'(c), ins.bit_sel, fl[k]);
                exp_pc      = tk ? pc + {{4{ins.offset[6]}}, ins.offset} + 11'h001 : pc + 11'h001;
                run(pc, fl[k]);
                check("branch pc", 16'(res.next_pc), 16'(exp_pc));
                check("branch cycles", 16'(cyc), tk ? 16'h0002 : 16'h0001);
                check("branch writes", 16'({res.flags_we, res.rd_we, res.io_we}), 16'h0000);
            end
        end
        $display("test_branches finished");
    endtask : test_branches

    task automatic test_skips;
        logic hit;
        for (int op = 1; op <= 4; op++) begin
            for (int b = 0; b < 16; b++) begin
                ins               = '0;
                ins.op            = bse_pkg::bse_op_t'(op);
                ins.bit_sel       = 3'(b);
                ins.io_addr       = 5'h1f;
                ins.next_two_word = b[3];
                ins.opnd          = op < 3 ? 8'h55 : io_val;
                hit               = ins.opnd[b[2:0]] == (op == 2 || op == 4);
                run(11'h100, 8'h00);
                check("skip pc", 16'(res.next_pc), hit ? 16'h0102 + 16'(b[3]) : 16'h0101);
                check("skip cycles", 16'(cyc), hit ? 16'h0002 + 16'(b[3]) : 16'h0001);
            end
        end
        $display("test_skips finished");
    endtask : test_skips

    task automatic test_shifts;
        logic [7:0] v [5] = '{8'h80, 8'h01, 8'h00, 8'h40, 8'hc3};
        logic [7:0] d;
        logic [7:0] f;
        logic [7:0] ef;
        for (int i = 0; i < 10; i++) begin
            ins      = '0;
            ins.op   = i < 5 ? bse_pkg::BSE_OP_SHIFT_LEFT : bse_pkg::BSE_OP_SHIFT_RIGHT;
            ins.opnd = v[i % 5];
            d        = i < 5 ? {ins.opnd[6:0], 1'b0} : {1'b0, ins.opnd[7:1]};
            f        = i[0] ? 8'hf0 : 8'h0f;
            ef       = f;
            ef[0]    = i < 5 ? ins.opnd[7] : ins.opnd[0];
            ef[1]    = d == 8'h00;
            ef[2]    = d[7];
            ef[3]    = d[7] ^ ef[0];
            run(11'h3ff, f);
            check("shift data", 16'(res.rd_data), 16'(d));
            check("shift flags", 16'(res.flags), 16'(ef));
            check("shift pc cycles", 16'({res.next_pc, 3'(cyc)}), 16'h2001);
        end
        $display("test_shifts finished");
    endtask : test_shifts

    initial begin
        clk             = 1'b0;
        reset           = 1'b1;
        instr_valid     = 1'b0;
        instr           = '0;
        ins             = '0;
        pc_in           = 11'h000;
        flags_in        = 8'h00;
        errors          = 0;
        samples_checked = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        check("idle after reset", 16'({instr_ready, result.done}), 16'h0002);
        ins = '0;
        run(11'h7ff, 8'h00);
        check("no-op pc cycles", 16'({res.next_pc, 3'(cyc)}), 16'h0001);
        test_io_bits();
        test_branches();
        test_skips();
        test_shifts();
        end_of_test();
    end
endmodule : branch_skip_bitop_exec_test

/* File: verification/bse_exec_props.sv */
// Checker of the execution block, bound to its top module.
`timescale 1ns/1ps
`include "bse_regs.svh"
module bse_exec_props (
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 instr_valid,
    input wire bse_pkg::bse_instr_t  instr,
    input wire logic [`BSE_PC_W-1:0] pc_in,
    input wire logic [7:0]           flags_in,
    input wire logic                 instr_ready,
    input wire bse_pkg::bse_result_t result
);
    // ==================================================================
    // Helpers
    logic                 acc;
    logic                 bit_one;
    logic [7:0]           mask;
    logic [`BSE_PC_W-1:0] tgt;
    assign acc     = instr_valid && instr_ready;
    assign mask    = 8'h01 << instr.bit_sel;
    assign bit_one = (instr.opnd & mask) != 8'h00;
    assign tgt     = pc_in + {{(`BSE_PC_W-`BSE_OFS_W){instr.offset[`BSE_OFS_W-1]}}, instr.offset} + `BSE_STEP_NEXT;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // ==================================================================
    // Assertions
    chk_skip_false_one: assert property (acc && instr.op == bse_pkg::BSE_OP_SKIP_REG_CLR && bit_one
        |=> result.done && result.next_pc == $past(pc_in) + `BSE_STEP_NEXT) else $error("skip taken wrongly");
    chk_skip_two_words: assert property (acc && instr.op == bse_pkg::BSE_OP_SKIP_REG_SET && bit_one
        && instr.next_two_word |=> !result.done [*2] ##1 result.done
        && result.next_pc == $past(pc_in, 3) + `BSE_STEP_SKIP2) else $error("long skip wrong");
    chk_io_skip_one: assert property (acc && instr.op == bse_pkg::BSE_OP_SKIP_IO_CLR && !bit_one
        && !instr.next_two_word |=> !result.done ##1 result.done
        && result.next_pc == $past(pc_in, 2) + `BSE_STEP_SKIP1) else $error("short skip wrong");
    chk_branch_generic: assert property (acc && instr.op == bse_pkg::BSE_OP_BRANCH
        && instr.cond == bse_pkg::BSE_BR_FLAG_SET_GENERIC && (flags_in & mask) != 8'h00
        |=> !instr_ready && !result.done ##1 result.done && result.next_pc == $past(tgt, 2))
        else $error("generic branch wrong");
    chk_branch_untaken: assert property (acc && instr.op == bse_pkg::BSE_OP_BRANCH
        && instr.cond == bse_pkg::BSE_BR_EQUAL && !flags_in[1]
        |=> result.done && result.next_pc == $past(pc_in) + `BSE_STEP_NEXT) else $error("equal branch wrong");
    chk_io_set_bit: assert property (acc && instr.op == bse_pkg::BSE_OP_IO_SET |=> !result.io_we ##1
        result.io_we && !result.flags_we && result.io_data == ($past(instr.opnd, 2) | $past(mask, 2)))
        else $error("io set wrong");
    chk_io_clr_bit: assert property (acc && instr.op == bse_pkg::BSE_OP_IO_CLR |=> !result.io_we ##1
        result.io_we && result.io_addr == $past(instr.io_addr, 2)
        && result.io_data == ($past(instr.opnd, 2) & ~$past(mask, 2))) else $error("io clear wrong");
    chk_shift_left: assert property (acc && instr.op == bse_pkg::BSE_OP_SHIFT_LEFT |=> result.rd_we
        && result.rd_data == {$past(instr.opnd[6:0]), 1'b0} && result.flags[0] == $past(instr.opnd[7]))
        else $error("left shift wrong");
    chk_shift_right: assert property (acc && instr.op == bse_pkg::BSE_OP_SHIFT_RIGHT |=> result.flags_we
        && result.rd_data == {1'b0, $past(instr.opnd[7:1])} && result.flags[0] == $past(instr.opnd[0])
        && result.flags[3] == (result.flags[2] ^ result.flags[0])) else $error("right shift wrong");

    // ==================================================================
    // Coverage
    cov_branch: cover property (acc && instr.op == bse_pkg::BSE_OP_BRANCH ##2 result.done);
    cov_skip3: cover property (acc && instr.op == bse_pkg::BSE_OP_SKIP_IO_SET ##3 result.done);
    cov_io: cover property (result.io_we);
endmodule : bse_exec_props

bind bse_exec bse_exec_props i_props (.clk, .reset, .instr_valid, .instr, .pc_in, .flags_in, .instr_ready, .result);

/* File: verification/bse_io_model.sv */
// Model of the low I/O register space behind the execution block.
`timescale 1ns/1ps
module bse_io_model (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic [4:0] rd_addr,
    output logic [7:0]     rd_data,
    input wire logic       wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [7:0] wr_data
);
    logic [7:0] mem_reg [32];
    // A write lands one edge after the strobe, so a read must wait a cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 32; i++) mem_reg[i] <= 8'h00;
        end else if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end
    assign rd_data = mem_reg[rd_addr];
endmodule : bse_io_model
